/* verilog/bridge_pkg.sv */
// Shared constants, register map and carrier types for the half-bridge input control.
// Assumes a single 50 MHz clock domain and AXI4-Lite register access.
package bridge_pkg;
  localparam int          CLK_HZ            = 50_000_000;
  localparam int          OFF_TIME_US       = 30;
  localparam int          OFF_TIME_CYCLES   = (CLK_HZ / 1_000_000) * OFF_TIME_US;
  localparam logic [7:0]  ADDR_MODE         = 8'h00;
  localparam logic [7:0]  ADDR_COMMAND      = 8'h04;
  localparam logic [7:0]  ADDR_PIN_CONTROL  = 8'h08;
  localparam logic [7:0]  ADDR_COMBINE      = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS       = 8'h10;
  localparam logic [1:0]  MODE_PH_EN        = 2'b00;
  localparam logic [1:0]  MODE_INDEPENDENT  = 2'b01;
  localparam logic [1:0]  MODE_RESET        = 2'b01;
  localparam logic [2:0]  UNLOCK_CODE       = 3'h5;
  localparam int          LOCK_LSB          = 0;
  localparam int          REG_DISABLE_A_BIT = 0;
  localparam int          REG_DISABLE_B_BIT = 1;
  localparam int          REG_INPUT_ONE_BIT = 2;
  localparam int          REG_INPUT_TWO_BIT = 3;
  localparam int          SEL_DISABLE_BIT   = 0;
  localparam int          SEL_ONE_BIT       = 1;
  localparam int          SEL_TWO_BIT       = 2;
  localparam int          TRIP_EN_BIT       = 2;
  localparam logic [3:0]  PIN_CONTROL_RESET = 4'h0;
  localparam logic [2:0]  COMBINE_RESET     = 3'h0;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef enum logic [1:0] {
    DRIVE_HIZ  = 2'b00,
    DRIVE_LOW  = 2'b01,
    DRIVE_HIGH = 2'b10
  } drive_type;

  typedef struct packed {
    logic sleep_bar_pin;
    logic driver_disable_pin;
    logic bridge_input_one;
    logic bridge_input_two;
  } pins_type;

  typedef struct packed {
    drive_type half_bridge_out_a;
    drive_type half_bridge_out_b;
    logic      sense_current_a;
    logic      sense_current_b;
  } drive_out_type;
endpackage

/* verilog/pin_sync.sv */
// Two-flop synchroniser for the external control pins.
// Assumes pins are asynchronous to aclk.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Pins
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } state_type;
  state_type state;
  state_type next_state;

  always_comb begin
    next_state        = state;
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;
endmodule

/* verilog/trip_timer.sv */
// Fixed off-time timer started by the current trip comparator.
// Assumes the trip input is already synchronous to aclk.
`timescale 1ns/100ps
module trip_timer #(
  parameter int OFF_CYCLES = 1500
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic start,
  input  wire logic cancel,
  output logic      active
);
  typedef struct packed {
    logic [15:0] count;
  } state_type;
  state_type state;
  state_type next_state;

  always_comb begin
    next_state = state;
    if (cancel) begin
      next_state.count = 16'h0000;
    end else if (start && state.count == 16'h0000) begin
      next_state.count = 16'(OFF_CYCLES);
    end else if (state.count != 16'h0000) begin
      next_state.count = state.count - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign active = (state.count != 16'h0000);
endmodule

/* verilog/half_bridge_input_control.sv */
// Decodes sleep, disable and input pins with register bits into half-bridge drive states.
// Assumes pins are asynchronous, registers reached over AXI4-Lite on aclk.
`timescale 1ns/100ps
module half_bridge_input_control
  import bridge_pkg::*;
#(
  parameter bit REGISTER_VARIANT = 1'b1,
  parameter int OFF_CYCLES       = bridge_pkg::OFF_TIME_CYCLES
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Control pins
  input  wire bridge_pkg::pins_type      pins,
  input  wire logic                      current_trip_limit,
  // Drive outputs
  output bridge_pkg::drive_out_type      drive,
  output logic                           standby,
  // AXI4-Lite write
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import bridge_pkg::*;

  typedef struct packed {
    logic [1:0]    mode;
    logic          unlocked;
    logic [3:0]    pin_control;
    logic [2:0]    combine;
    logic          trip_enable;
    logic          aw_held;
    logic [7:0]    aw_addr;
    logic          w_held;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          prev_one;
    logic          prev_two;
    drive_out_type drive;
    logic          standby;
    logic          awready;
    logic          wready;
    logic          arready;
  } state_type;

  state_type state;
  state_type next_state;
  logic [4:0] sync_pins;
  logic       timer_active;
  logic       timer_start;
  logic       timer_cancel;

  function automatic logic combine_bit(input logic pin, input logic bitv, input logic sel);
    combine_bit = sel ? (pin & bitv) : (pin | bitv);
  endfunction

  function automatic drive_type half_drive(input logic off, input logic level, input logic chop);
    if (off) begin
      half_drive = DRIVE_HIZ;
    end else if (level && !chop) begin
      half_drive = DRIVE_HIGH;
    end else begin
      half_drive = DRIVE_LOW;
    end
  endfunction

  pin_sync #(.WIDTH(5)) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pins, current_trip_limit}),
    .sync_out (sync_pins)
  );

  trip_timer #(.OFF_CYCLES(OFF_CYCLES)) u_trip_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (timer_start),
    .cancel  (timer_cancel),
    .active  (timer_active)
  );

  pins_type sp;
  logic     trip_s;
  logic     use_regs;
  logic     in_one;
  logic     in_two;
  logic     off_a;
  logic     off_b;
  logic     indep;
  assign sp       = pins_type'(sync_pins[4:1]);
  assign trip_s   = sync_pins[0];
  assign use_regs = REGISTER_VARIANT && state.unlocked;
  assign indep    = (state.mode == MODE_INDEPENDENT);
  // Combined inputs
  assign in_one = use_regs ? combine_bit(sp.bridge_input_one,
                                         state.pin_control[REG_INPUT_ONE_BIT],
                                         state.combine[SEL_ONE_BIT])
                           : sp.bridge_input_one;
  assign in_two = use_regs ? combine_bit(sp.bridge_input_two,
                                         state.pin_control[REG_INPUT_TWO_BIT],
                                         state.combine[SEL_TWO_BIT])
                           : sp.bridge_input_two;
  assign off_a  = use_regs ? combine_bit(sp.driver_disable_pin,
                                         state.pin_control[REG_DISABLE_A_BIT],
                                         state.combine[SEL_DISABLE_BIT])
                           : sp.driver_disable_pin;
  assign off_b  = use_regs ? combine_bit(sp.driver_disable_pin,
                                         state.pin_control[REG_DISABLE_B_BIT],
                                         state.combine[SEL_DISABLE_BIT])
                           : sp.driver_disable_pin;
  // Trip starts only while some output sources current; input change cancels
  assign timer_start  = state.trip_enable && trip_s &&
                        (state.drive.sense_current_a || state.drive.sense_current_b);
  assign timer_cancel = (in_one != state.prev_one) || (in_two != state.prev_two);

  always_comb begin
    logic          wr_go;
    logic          rd_go;
    logic [31:0]   wd;
    drive_type     da;
    drive_type     db;
    wr_go = 1'b0;
    rd_go = 1'b0;
    wd    = 32'h0000_0000;
    da    = DRIVE_HIZ;
    db    = DRIVE_HIZ;
    next_state = state;
    next_state.prev_one = in_one;
    next_state.prev_two = in_two;
    // Bus handshakes
    if (!state.aw_held && s_axi_awvalid) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (!state.w_held && s_axi_wvalid) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    wr_go = state.aw_held && state.w_held && !state.bvalid;
    if (wr_go) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = RESP_OKAY;
      wd = state.w_data;
      if (!state.w_strb[0]) begin
        next_state.bresp = RESP_OKAY;
      end else if (state.aw_addr == ADDR_MODE) begin
        next_state.mode        = wd[1:0];
        next_state.trip_enable = wd[TRIP_EN_BIT];
      end else if (state.aw_addr == ADDR_COMMAND) begin
        next_state.unlocked = (wd[LOCK_LSB +: 3] == UNLOCK_CODE);
      end else if (state.aw_addr == ADDR_PIN_CONTROL) begin
        next_state.pin_control = wd[3:0];
      end else if (state.aw_addr == ADDR_COMBINE) begin
        next_state.combine = wd[2:0];
      end else if (state.aw_addr != ADDR_STATUS) begin
        next_state.bresp = RESP_SLVERR;
      end
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
    rd_go = s_axi_arvalid && !state.rvalid;
    if (rd_go) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = RESP_OKAY;
      next_state.rdata  = 32'h0000_0000;
      if (s_axi_araddr == ADDR_MODE) begin
        next_state.rdata[2:0] = {state.trip_enable, state.mode};
      end else if (s_axi_araddr == ADDR_COMMAND) begin
        next_state.rdata[3] = state.unlocked;
      end else if (s_axi_araddr == ADDR_PIN_CONTROL) begin
        next_state.rdata[3:0] = state.pin_control;
      end else if (s_axi_araddr == ADDR_COMBINE) begin
        next_state.rdata[2:0] = state.combine;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        next_state.rdata[7:0] = {timer_active, state.standby,
                                 state.drive.half_bridge_out_a,
                                 state.drive.half_bridge_out_b,
                                 state.drive.sense_current_a,
                                 state.drive.sense_current_b};
      end else begin
        next_state.rresp = RESP_SLVERR;
      end
    end
    // Drive decode; sleep only from its pin
    if (!sp.sleep_bar_pin) begin
      da = DRIVE_HIZ;
      db = DRIVE_HIZ;
    end else if (indep) begin
      da = half_drive(off_a, in_one, timer_active);
      db = half_drive(off_b, in_two, timer_active);
    end else begin
      da = half_drive(off_a, in_one, 1'b0);
      db = half_drive(off_a, in_two, 1'b0);
    end
    next_state.drive.half_bridge_out_a = da;
    next_state.drive.half_bridge_out_b = db;
    next_state.drive.sense_current_a   = (da == DRIVE_HIGH);
    next_state.drive.sense_current_b   = (db == DRIVE_HIGH);
    next_state.standby = sp.sleep_bar_pin && off_a && (off_b || !indep);
    next_state.awready = !next_state.aw_held;
    next_state.wready  = !next_state.w_held;
    next_state.arready = !next_state.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state             <= '0;
      state.mode        <= MODE_RESET;
      state.pin_control <= PIN_CONTROL_RESET;
      state.combine     <= COMBINE_RESET;
      state.awready     <= 1'b1;
      state.wready      <= 1'b1;
      state.arready     <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign drive         = state.drive;
  assign standby       = state.standby;
  assign s_axi_awready = state.awready;
  assign s_axi_wready  = state.wready;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  a_sleep_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
    !sp.sleep_bar_pin |=> drive.half_bridge_out_a == DRIVE_HIZ
                          && drive.half_bridge_out_b == DRIVE_HIZ)
    else $error("Sleep did not give Hi-Z");
  a_sense_high: assert property (@(posedge aclk) disable iff (!aresetn)
    drive.sense_current_a == (drive.half_bridge_out_a == DRIVE_HIGH))
    else $error("Sense flag a wrong");
  a_sense_none: assert property (@(posedge aclk) disable iff (!aresetn)
    standby |-> !drive.sense_current_a && !drive.sense_current_b)
    else $error("Sense current in standby");
  a_trip_low: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_active && indep && sp.sleep_bar_pin
    |=> drive.half_bridge_out_a != DRIVE_HIGH)
    else $error("High output during off time");
  a_lock_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    !use_regs |-> off_a == sp.driver_disable_pin && off_b == off_a)
    else $error("Register bits acted while locked");
  a_or_combine: assert property (@(posedge aclk) disable iff (!aresetn)
    use_regs && !state.combine[SEL_TWO_BIT]
    |-> in_two == (sp.bridge_input_two | state.pin_control[REG_INPUT_TWO_BIT]))
    else $error("OR combine wrong");
  a_and_combine: assert property (@(posedge aclk) disable iff (!aresetn)
    use_regs && state.combine[SEL_ONE_BIT]
    |-> in_one == (sp.bridge_input_one & state.pin_control[REG_INPUT_ONE_BIT]))
    else $error("AND combine wrong");
  a_split_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
    sp.sleep_bar_pin && indep && off_a && !off_b
    |=> drive.half_bridge_out_a == DRIVE_HIZ && drive.half_bridge_out_b != DRIVE_HIZ)
    else $error("Split disable wrong");
  a_follow_in: assert property (@(posedge aclk) disable iff (!aresetn)
    sp.sleep_bar_pin && indep && !off_b && !timer_active
    |=> drive.half_bridge_out_b == ($past(in_two) ? DRIVE_HIGH : DRIVE_LOW))
    else $error("Output b does not follow input");
endmodule

/* verification/host_pin_driver.sv */
// Host-side model of the control pins feeding the bridge block.
// Assumes the bench sets levels; a released pin settles at its pull.
`timescale 1ns/100ps
module host_pin_driver (
  // Requests from the bench
  input  wire bridge_pkg::pins_type level_req,
  input  wire logic                 release_req,
  // Pins
  output bridge_pkg::pins_type      pins
);
  import bridge_pkg::*;
  // Released: sleep and inputs pulled down, disable pulled up
  assign pins = release_req ? pins_type'(4'h4) : level_req;
endmodule

/* verification/tb_half_bridge_input_control.sv */
// Self-checking bench for the half-bridge input control block.
// Assumes the host pin model beside it; registers reached over AXI4-Lite.
`timescale 1ns/100ps
module tb_half_bridge_input_control;
  import bridge_pkg::*;
  localparam int OFF_SIM = 20;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  pins_type      level_req = 4'h4;
  logic          release_req = 1'b1;
  pins_type      pins;
  logic          trip = 1'b0;
  drive_out_type drive;
  drive_out_type drive_pin;
  logic          standby;
  logic [7:0]    awaddr = 8'h00;
  logic [7:0]    araddr = 8'h00;
  logic [31:0]   wdata = 32'h0;
  logic [3:0]    wstrb = 4'h0;
  logic          awvalid = 1'b0;
  logic          wvalid = 1'b0;
  logic          bready = 1'b0;
  logic          arvalid = 1'b0;
  logic          rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid;
  logic [1:0]    bresp, rresp, rs;
  logic [31:0]   rdata, rd;
  logic          unl = 1'b0;
  logic [3:0]    pc = 4'h0;
  logic [2:0]    sel = 3'h0;
  logic [1:0]    mode = MODE_RESET;
  int            num_errors = 0;
  int            tests_run = 0;

  always #10 aclk = ~aclk;

  host_pin_driver host_pin_driver_i (.level_req(level_req), .release_req(release_req),
    .pins(pins));

  half_bridge_input_control #(.REGISTER_VARIANT(1'b1), .OFF_CYCLES(OFF_SIM))
    half_bridge_input_control_i (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .current_trip_limit(trip), .drive(drive), .standby(standby), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // Pin-only variant sees the same pins and register writes
  half_bridge_input_control #(.REGISTER_VARIANT(1'b0), .OFF_CYCLES(OFF_SIM))
    half_bridge_input_control_pin_i (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .current_trip_limit(trip), .drive(drive_pin), .standby(), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready));

  function automatic logic comb(input logic p, input logic r, input logic s);
    return s ? (p & r) : (p | r);
  endfunction

  function automatic drive_out_type expect_drive(input pins_type p, input bit regv);
    logic          da, db, i1, i2;
    drive_out_type e;
    da = p.driver_disable_pin;
    db = da;
    i1 = p.bridge_input_one;
    i2 = p.bridge_input_two;
    if (regv && unl) begin
      da = comb(p.driver_disable_pin, pc[REG_DISABLE_A_BIT], sel[SEL_DISABLE_BIT]);
      db = comb(p.driver_disable_pin, pc[REG_DISABLE_B_BIT], sel[SEL_DISABLE_BIT]);
      db = (mode == MODE_INDEPENDENT) ? db : da;
      i1 = comb(i1, pc[REG_INPUT_ONE_BIT], sel[SEL_ONE_BIT]);
      i2 = comb(i2, pc[REG_INPUT_TWO_BIT], sel[SEL_TWO_BIT]);
    end
    e.half_bridge_out_a = (!p.sleep_bar_pin || da) ? DRIVE_HIZ : (i1 ? DRIVE_HIGH : DRIVE_LOW);
    e.half_bridge_out_b = (!p.sleep_bar_pin || db) ? DRIVE_HIZ : (i2 ? DRIVE_HIGH : DRIVE_LOW);
    e.sense_current_a = (e.half_bridge_out_a == DRIVE_HIGH);
    e.sense_current_b = (e.half_bridge_out_b == DRIVE_HIGH);
    return e;
  endfunction

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic done;
    done = 1'b0;
    r = 2'b11;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    d = 32'hFFFFFFFF;
    r = 2'b11;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hF, r);
    check("write resp", 32'(RESP_OKAY), 32'(r));
  endtask

  // Set pins, let them settle, compare both variants and the status word
  task automatic apply(input pins_type p);
    drive_out_type e;
    logic          stb;
    @(posedge aclk);
    level_req <= p;
    repeat (6) @(posedge aclk);
    e = expect_drive(p, 1'b1);
    stb = p.sleep_bar_pin && e.half_bridge_out_a == DRIVE_HIZ && e.half_bridge_out_b == DRIVE_HIZ;
    check("drive", {26'h0, e}, {26'h0, drive});
    check("drive pin variant", {26'h0, expect_drive(p, 1'b0)}, {26'h0, drive_pin});
    check("standby", {31'h0, stb}, {31'h0, standby});
    axi_read(ADDR_STATUS, rd, rs);
    check("status", {25'h0, stb, e}, rd & 32'h7F);
  endtask

  task automatic trip_pulse();
    @(posedge aclk);
    trip <= 1'b1;
    repeat (2) @(posedge aclk);
    trip <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    apply(4'h4);
    release_req <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      axi_read(8'((i == 0) ? 0 : 4 * i + 4), rd, rs);
      check("reset value", (i == 0) ? 32'(MODE_RESET) : 32'h0, rd);
    end
    axi_read(8'h14, rd, rs);
    check("unmapped read", 32'(RESP_SLVERR), 32'(rs));
    axi_write(8'h14, 32'hF, 4'hF, rs);
    check("unmapped write", 32'(RESP_SLVERR), 32'(rs));
    for (int i = 0; i < 16; i++) apply(pins_type'(4'(i)));
    wr(ADDR_PIN_CONTROL, 32'hF);
    pc = 4'hF;
    apply(4'h8);
    wr(ADDR_COMMAND, 32'(UNLOCK_CODE));
    unl = 1'b1;
    axi_read(ADDR_COMMAND, rd, rs);
    check("unlocked flag", 32'h1, {31'h0, rd[3]});
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_COMBINE, 32'(s));
      sel = 3'(s);
      for (int c = 0; c < 16; c++) begin
        wr(ADDR_PIN_CONTROL, 32'(c));
        pc = 4'(c);
        for (int p = 8; p < 16; p++) apply(pins_type'(4'(p)));
      end
    end
    apply(4'h3);
    axi_write(ADDR_PIN_CONTROL, 32'h0, 4'h0, rs);
    check("strobe off resp", 32'(RESP_OKAY), 32'(rs));
    axi_write(ADDR_STATUS, 32'hFF, 4'hF, rs);
    check("status write resp", 32'(RESP_OKAY), 32'(rs));
    axi_read(ADDR_PIN_CONTROL, rd, rs);
    check("pin control kept", 32'hF, rd);
    wr(ADDR_COMBINE, 32'h0);
    sel = 3'h0;
    wr(ADDR_PIN_CONTROL, 32'h2);
    pc = 4'h2;
    apply(4'hB);
    wr(ADDR_MODE, 32'(MODE_PH_EN));
    mode = MODE_PH_EN;
    apply(4'hB);
    wr(ADDR_MODE, 32'(MODE_INDEPENDENT));
    mode = MODE_INDEPENDENT;
    wr(ADDR_COMMAND, 32'h0);
    unl = 1'b0;
    apply(4'hB);
    wr(ADDR_MODE, 32'h5);
    apply(4'hA);
    trip_pulse();
    check("tripped out_a", {30'h0, DRIVE_LOW}, {30'h0, drive.half_bridge_out_a});
    repeat (OFF_SIM + 10) @(posedge aclk);
    check("off time over", {30'h0, DRIVE_HIGH}, {30'h0, drive.half_bridge_out_a});
    trip_pulse();
    apply(4'hB);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    pc = 4'h0;
    mode = MODE_RESET;
    apply(4'hA);
    axi_read(ADDR_MODE, rd, rs);
    check("mode after reset", 32'(MODE_RESET), rd);
    stop_test();
  end
endmodule
